// ### apb_decode.v
// APB address decode for the pad control block: phase strobes and one-hot
// register selects. Assumes a compliant APB master that holds its request.
`include "pad_defines.vh"
module apb_decode (
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`PAD_ADDR_W-1:0] paddr,
    output wire setup,
    output wire wr_commit,
    output wire sel_data,
    output wire sel_dir,
    output wire sel_pullup,
    output wire sel_slew,
    output wire sel_drive,
    output wire sel_pull_state,
    output wire sel_drive_state,
    output wire hit
);
    // Setup is the cycle the slave prepares its answer
    assign setup = psel & ~penable;
    assign wr_commit = psel & penable & pwrite;

    // Register selects
    assign sel_data = (paddr == `OFF_PORT_DATA);
    assign sel_dir = (paddr == `OFF_PORT_DIR);
    assign sel_pullup = (paddr == `OFF_PULLUP);
    assign sel_slew = (paddr == `OFF_SLEW);
    assign sel_drive = (paddr == `OFF_DRIVE);
    assign sel_pull_state = (paddr == `OFF_PULL_STATE);
    assign sel_drive_state = (paddr == `OFF_DRIVE_STATE);
    assign hit = sel_data | sel_dir | sel_pullup | sel_slew | sel_drive |
                 sel_pull_state | sel_drive_state;
endmodule // apb_decode

// ### pad_cell.v
// Pad steering for one port of pins: output mux, output enable, and the
// gating of pull-up, slew and drive. Purely combinational; the caller registers.
// Assumes peripheral and analog ownership flags come from synchronous logic.
module pad_cell #(
    parameter WIDTH = 8
) (
    input wire [WIDTH-1:0] gpio_data,
    input wire [WIDTH-1:0] gpio_dir,
    input wire [WIDTH-1:0] periph_ctrl,
    input wire [WIDTH-1:0] periph_oe,
    input wire [WIDTH-1:0] periph_out,
    input wire [WIDTH-1:0] analog_sel,
    input wire [WIDTH-1:0] pad_pullup_enable_bit,
    input wire [WIDTH-1:0] pad_slew_limit_enable_bit,
    input wire [WIDTH-1:0] pad_high_drive_select_bit,
    output wire [WIDTH-1:0] drive_nxt,
    output wire [WIDTH-1:0] out_nxt,
    output wire [WIDTH-1:0] pullup_nxt,
    output wire [WIDTH-1:0] slew_nxt,
    output wire [WIDTH-1:0] high_drive_nxt
);
    wire [WIDTH-1:0] dig_oe;

    // Peripheral takes the buffer when it owns the pin; analog owns it outright
    assign dig_oe = (periph_ctrl & periph_oe) | (~periph_ctrl & gpio_dir);
    assign drive_nxt = dig_oe & ~analog_sel;
    assign out_nxt = (periph_ctrl & periph_out) | (~periph_ctrl & gpio_data);

    // Pull-up only on a non-driving, non-analog pin
    assign pullup_nxt = pad_pullup_enable_bit & ~dig_oe & ~analog_sel;

    // Slew and strength only matter while the pin drives
    assign slew_nxt = pad_slew_limit_enable_bit & drive_nxt;
    assign high_drive_nxt = pad_high_drive_select_bit & drive_nxt;
endmodule // pad_cell

// ### pad_ctrl.v
// Pad control for two 8-bit parallel ports: port data and direction,
// plus pull-up, slew and drive-strength bits in a separate register page.
// Assumes synchronous pin, peripheral and analog inputs on pclk, and an
// APB master that follows the usual setup/access sequence.
//
// Decided for this implementation: the APB slave port and the register offsets.
`include "pad_defines.vh"

module pad_ctrl (
    // APB slave side
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`PAD_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Pin levels and ownership flags, all synchronous to pclk
    input wire [`PAD_PIN_W-1:0] pad_in,
    input wire [`PAD_PIN_W-1:0] periph_ctrl,
    input wire [`PAD_PIN_W-1:0] periph_oe,
    input wire [`PAD_PIN_W-1:0] periph_out,
    input wire [`PAD_PIN_W-1:0] analog_sel,
    // Pad controls, every one straight from a flip-flop
    output reg [`PAD_PIN_W-1:0] pad_out,
    output reg [`PAD_PIN_W-1:0] pad_oe_n,
    output reg [`PAD_PIN_W-1:0] pad_pullup_on,
    output reg [`PAD_PIN_W-1:0] pad_slew_on,
    output reg [`PAD_PIN_W-1:0] pad_high_drive_on
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    // Software-visible registers
    reg [`PAD_PIN_W-1:0] port_data_r;
    reg [`PAD_PIN_W-1:0] port_dir_r;
    reg [`PAD_PIN_W-1:0] pad_pullup_enable_bit_r;
    reg [`PAD_PIN_W-1:0] pad_slew_limit_enable_bit_r;
    reg [`PAD_PIN_W-1:0] pad_high_drive_select_bit_r;
    // Next values from the write path and the read data mux
    reg [`PAD_PIN_W-1:0] port_data_nxt;
    reg [`PAD_PIN_W-1:0] port_dir_nxt;
    reg [`PAD_PIN_W-1:0] pullup_bits_nxt;
    reg [`PAD_PIN_W-1:0] slew_bits_nxt;
    reg [`PAD_PIN_W-1:0] drive_bits_nxt;
    reg [31:0] rdata_nxt;
    // Bus decode strobes
    wire setup;
    wire wr_commit;
    wire sel_data;
    wire sel_dir;
    wire sel_pullup;
    wire sel_slew;
    wire sel_drive;
    wire sel_pull_state;
    wire sel_drive_state;
    wire hit;
    // Steering results, one bit per pin
    wire [`PAD_PIN_W-1:0] drive_nxt;
    wire [`PAD_PIN_W-1:0] out_nxt;
    wire [`PAD_PIN_W-1:0] pullup_nxt;
    wire [`PAD_PIN_W-1:0] slew_nxt;
    wire [`PAD_PIN_W-1:0] high_drive_nxt;
    // Read view of port data and trimmed write data
    wire [`PAD_PIN_W-1:0] data_view;
    wire [`PAD_PIN_W-1:0] wdata16;

    // ------------------------------------------------------------------
    // Register map: byte offsets, one word each, pins in bits 15:0
    // ------------------------------------------------------------------
    // 0x00 port data: a write loads the output latch; a read follows the
    //      direction bit, latch for an output and pin level for an input
    // 0x04 direction: 1 makes the pin an output unless a peripheral or analog function owns it
    // 0x40 pull-up enable: honoured only on a pin that nothing drives
    // 0x44 slew limit enable: honoured only on a driven pin
    // 0x48 high drive select: honoured only on a driven pin
    // 0x4C effective pull-up, read only, as the pads see it now
    // 0x50 effective drive enable, read only, the inverse of pad_oe_n
    // Writes to the two read-only words are dropped without an error, so
    // a read-modify-write loop over the whole page stays harmless; any
    // other offset answers with pslverr and leaves every register alone.
    //
    // Ownership of a pin, strongest first:
    //   analog function - buffer off, pull-up off, slew and drive moot
    //   peripheral      - its own enable and level reach the buffer
    //   port logic      - direction and data registers
    // A peripheral pin that only listens keeps its pull-up: the pull-up is
    // cut by whatever drives the pin, not by who owns it.
    //
    // Bus timing: pready rises in the first access cycle of every
    // transfer, so each transfer takes two cycles with no wait state.
    // Read data is captured in setup, so a read of the pins shows their
    // level one edge before the transfer completes.
    //
    // Limitations: there are no byte strobes, so a write always replaces
    // all sixteen pins of a register. Pin inputs are taken as already
    // synchronous to pclk; a pin from another clock domain needs a
    // synchroniser outside this block, or a read may catch it mid-change.

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    apb_decode u_decode (
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .setup(setup),
        .wr_commit(wr_commit),
        .sel_data(sel_data),
        .sel_dir(sel_dir),
        .sel_pullup(sel_pullup),
        .sel_slew(sel_slew),
        .sel_drive(sel_drive),
        .sel_pull_state(sel_pull_state),
        .sel_drive_state(sel_drive_state),
        .hit(hit)
    );

    // Only the low half of the bus word carries pin bits
    assign wdata16 = pwdata[`PAD_PIN_W-1:0];

    // ------------------------------------------------------------------
    // Pad steering, one instance per port
    // ------------------------------------------------------------------
    pad_cell #(
        .WIDTH(`PAD_PORT_W)
    ) u_port_a (
        .gpio_data(port_data_r[7:0]),
        .gpio_dir(port_dir_r[7:0]),
        .periph_ctrl(periph_ctrl[7:0]),
        .periph_oe(periph_oe[7:0]),
        .periph_out(periph_out[7:0]),
        .analog_sel(analog_sel[7:0]),
        .pad_pullup_enable_bit(pad_pullup_enable_bit_r[7:0]),
        .pad_slew_limit_enable_bit(pad_slew_limit_enable_bit_r[7:0]),
        .pad_high_drive_select_bit(pad_high_drive_select_bit_r[7:0]),
        .drive_nxt(drive_nxt[7:0]),
        .out_nxt(out_nxt[7:0]),
        .pullup_nxt(pullup_nxt[7:0]),
        .slew_nxt(slew_nxt[7:0]),
        .high_drive_nxt(high_drive_nxt[7:0])
    );

    pad_cell #(
        .WIDTH(`PAD_PORT_W)
    ) u_port_b (
        .gpio_data(port_data_r[15:8]),
        .gpio_dir(port_dir_r[15:8]),
        .periph_ctrl(periph_ctrl[15:8]),
        .periph_oe(periph_oe[15:8]),
        .periph_out(periph_out[15:8]),
        .analog_sel(analog_sel[15:8]),
        .pad_pullup_enable_bit(pad_pullup_enable_bit_r[15:8]),
        .pad_slew_limit_enable_bit(pad_slew_limit_enable_bit_r[15:8]),
        .pad_high_drive_select_bit(pad_high_drive_select_bit_r[15:8]),
        .drive_nxt(drive_nxt[15:8]),
        .out_nxt(out_nxt[15:8]),
        .pullup_nxt(pullup_nxt[15:8]),
        .slew_nxt(slew_nxt[15:8]),
        .high_drive_nxt(high_drive_nxt[15:8])
    );

    // ------------------------------------------------------------------
    // Port data read view
    // ------------------------------------------------------------------
    // Direction bit alone picks latch or pin, peripheral ownership ignored
    assign data_view = (port_dir_r & port_data_r) | (~port_dir_r & pad_in);

    // ------------------------------------------------------------------
    // Register write path
    // ------------------------------------------------------------------
    // Each select touches only its own register, so the pages stay apart
    // A write lands only at the access edge, where pready is high
    always @* begin
        port_data_nxt = port_data_r;
        port_dir_nxt = port_dir_r;
        pullup_bits_nxt = pad_pullup_enable_bit_r;
        slew_bits_nxt = pad_slew_limit_enable_bit_r;
        drive_bits_nxt = pad_high_drive_select_bit_r;
        if (wr_commit && pready) begin
            if (sel_data) begin
                port_data_nxt = wdata16;
            end
            if (sel_dir) begin
                port_dir_nxt = wdata16;
            end
            if (sel_pullup) begin
                pullup_bits_nxt = wdata16;
            end
            if (sel_slew) begin
                slew_bits_nxt = wdata16;
            end
            if (sel_drive) begin
                drive_bits_nxt = wdata16;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read data mux
    // ------------------------------------------------------------------
    // Status words show what the pads really get after all overrides
    // Bits 31:16 always read as zero
    always @* begin
        rdata_nxt = `RST_RDATA;
        if (sel_data) begin
            rdata_nxt[`PAD_PIN_W-1:0] = data_view;
        end else if (sel_dir) begin
            rdata_nxt[`PAD_PIN_W-1:0] = port_dir_r;
        end else if (sel_pullup) begin
            rdata_nxt[`PAD_PIN_W-1:0] = pad_pullup_enable_bit_r;
        end else if (sel_slew) begin
            rdata_nxt[`PAD_PIN_W-1:0] = pad_slew_limit_enable_bit_r;
        end else if (sel_drive) begin
            rdata_nxt[`PAD_PIN_W-1:0] = pad_high_drive_select_bit_r;
        end else if (sel_pull_state) begin
            rdata_nxt[`PAD_PIN_W-1:0] = pad_pullup_on;
        end else if (sel_drive_state) begin
            rdata_nxt[`PAD_PIN_W-1:0] = ~pad_oe_n;
        end
    end

    // ------------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------------
    // Answer is prepared in setup so pready is high for the first access
    // cycle; a registered pready costs no wait state this way
    // pslverr flags only offsets outside the map, never the read-only words
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `RST_RDATA;
        end else begin
            if (setup) begin
                pready <= 1'b1;
                pslverr <= ~hit;
                prdata <= pwrite ? `RST_RDATA : rdata_nxt;
            end else begin
                pready <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    // Everything clears on reset: inputs, no pull-up, slow off, low drive
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_data_r <= `RST_PIN_BITS;
            port_dir_r <= `RST_PIN_BITS;
            pad_pullup_enable_bit_r <= `RST_PIN_BITS;
            pad_slew_limit_enable_bit_r <= `RST_PIN_BITS;
            pad_high_drive_select_bit_r <= `RST_PIN_BITS;
        end else begin
            port_data_r <= port_data_nxt;
            port_dir_r <= port_dir_nxt;
            pad_pullup_enable_bit_r <= pullup_bits_nxt;
            pad_slew_limit_enable_bit_r <= slew_bits_nxt;
            pad_high_drive_select_bit_r <= drive_bits_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Pad outputs
    // ------------------------------------------------------------------
    // Registered so pads never see decode glitches; costs one cycle of
    // latency from a register write or ownership change to the pin.
    // A stale level can still appear if software sets direction before
    // data; that ordering is left to software.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_out <= `RST_PIN_BITS;
            pad_oe_n <= ~`RST_OE_N;
            pad_pullup_on <= `RST_PIN_BITS;
            pad_slew_on <= `RST_PIN_BITS;
            pad_high_drive_on <= `RST_PIN_BITS;
        end else begin
            pad_out <= out_nxt;
            pad_oe_n <= ~drive_nxt;
            pad_pullup_on <= pullup_nxt;
            pad_slew_on <= slew_nxt;
            pad_high_drive_on <= high_drive_nxt;
        end
    end

endmodule // pad_ctrl

// ### pad_defines.vh
// Constants for the pad control block: register byte offsets, field
// widths and reset values. Assumes a 32-bit APB bus and 16 pins (two ports).
`ifndef PAD_DEFINES_VH
`define PAD_DEFINES_VH

// ------------------------------------------------------------------
// Geometry
// ------------------------------------------------------------------
`define PAD_PORT_W 8
`define PAD_PIN_W 16
`define PAD_ADDR_W 8

// ------------------------------------------------------------------
// Port page: data and direction
// ------------------------------------------------------------------
`define OFF_PORT_DATA 8'h00
`define OFF_PORT_DIR 8'h04

// ------------------------------------------------------------------
// High page: pad control, kept apart from the port page
// ------------------------------------------------------------------
`define OFF_PULLUP 8'h40
`define OFF_SLEW 8'h44
`define OFF_DRIVE 8'h48
`define OFF_PULL_STATE 8'h4C
`define OFF_DRIVE_STATE 8'h50

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define RST_PIN_BITS 16'h0000
`define RST_OE_N 16'h0000
`define RST_RDATA 32'h0000_0000

`endif

// ### pad_monitor.sv
// Checker for pad_ctrl: pad gating at the pins and APB answer timing.
// Assumes it is bound to pad_ctrl and sees only that module's ports.
// ------------------------------------------------------------------
// Pad and bus relations
// ------------------------------------------------------------------
module pad_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] periph_ctrl,
    input wire logic [15:0] periph_oe,
    input wire logic [15:0] periph_out,
    input wire logic [15:0] analog_sel,
    input wire logic [15:0] pad_out,
    input wire logic [15:0] pad_oe_n,
    input wire logic [15:0] pad_pullup_on,
    input wire logic [15:0] pad_slew_on,
    input wire logic [15:0] pad_high_drive_on
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    pull_drive_excl_a: assert property ((pad_pullup_on & ~pad_oe_n) == 16'h0000)
        else $error("pull-up on while the pin drives");
    periph_pull_off_a: assert property (
        (pad_pullup_on & $past(periph_ctrl) & $past(periph_oe)) == 16'h0000)
        else $error("pull-up on while a peripheral drives");
    analog_off_a: assert property (
        ((pad_pullup_on | ~pad_oe_n) & $past(analog_sel)) == 16'h0000)
        else $error("analog pin pulled up or driven");
    slew_input_a: assert property ((pad_slew_on & pad_oe_n) == 16'h0000)
        else $error("slew limit on an input pin");
    drive_input_a: assert property ((pad_high_drive_on & pad_oe_n) == 16'h0000)
        else $error("high drive on an input pin");
    // Skips the first edge after reset, where the pads still show reset values
    periph_steer_a: assert property ($past(presetn) |->
        (((pad_oe_n ^ ~$past(periph_oe)) | (pad_out ^ $past(periph_out)))
        & $past(periph_ctrl) & ~$past(analog_sel)) == 16'h0000)
        else $error("peripheral pin not steered");
    reset_state_a: assert property (!$past(presetn) |-> pad_oe_n == 16'hFFFF &&
        pad_pullup_on == 16'h0000 && pad_slew_on == 16'h0000 && pad_high_drive_on == 16'h0000)
        else $error("pads not idle after reset");
    apb_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("ready not a single cycle after setup");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside an access cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule // pad_monitor

bind pad_ctrl pad_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .periph_ctrl(periph_ctrl),
    .periph_oe(periph_oe), .periph_out(periph_out), .analog_sel(analog_sel),
    .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pullup_on(pad_pullup_on),
    .pad_slew_on(pad_slew_on), .pad_high_drive_on(pad_high_drive_on));

// ### pin_model.sv
// Pin model: each pin is driven by the block, pulled up, or left floating.
// Assumes the block's pad outputs are registered on pclk.
module pin_model (
    input wire logic pclk,
    input wire logic [15:0] pad_out,
    input wire logic [15:0] pad_oe_n,
    input wire logic [15:0] pad_pullup_on,
    output logic [15:0] pad_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic float_r = 1'b0;

    // A floating pin changes every cycle so it never reads back as a lucky level
    always @(posedge pclk) begin
        float_r <= ~float_r;
    end

    // Driven level wins, then the pull-up, then the floating pattern
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            pad_in[i] = !pad_oe_n[i] ? pad_out[i] : (pad_pullup_on[i] ? 1'b1 : float_r);
        end
    end
endmodule // pin_model

// ### tb.sv
// Testbench for pad_ctrl: APB register tasks and pad checks.
// Assumes pin_model on the pins and the checker bound to the block.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [15:0] pad_in, periph_ctrl, periph_oe, periph_out, analog_sel;
    logic [15:0] pad_out, pad_oe_n, pad_pullup_on, pad_slew_on, pad_high_drive_on;
    int error_cnt = 0;
    int compares = 0;

    pad_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pad_in(pad_in), .periph_ctrl(periph_ctrl), .periph_oe(periph_oe),
        .periph_out(periph_out), .analog_sel(analog_sel), .pad_out(pad_out),
        .pad_oe_n(pad_oe_n), .pad_pullup_on(pad_pullup_on), .pad_slew_on(pad_slew_on),
        .pad_high_drive_on(pad_high_drive_on));
    pin_model u_pins (.pclk(pclk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .pad_pullup_on(pad_pullup_on), .pad_in(pad_in));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(name, rdat, exp);
    endtask

    // Pads settle one cycle after a change; three cycles leave margin
    task automatic pads(input logic [15:0] oe_n, pu, sl, hd);
        repeat (3) @(posedge pclk);
        #1;
        chk("pad_oe_n", {16'h0000, pad_oe_n}, {16'h0000, oe_n});
        chk("pad_pullup_on", {16'h0000, pad_pullup_on}, {16'h0000, pu});
        chk("pad_slew_on", {16'h0000, pad_slew_on}, {16'h0000, sl});
        chk("pad_high_drive_on", {16'h0000, pad_high_drive_on}, {16'h0000, hd});
    endtask

    task automatic complete_run;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Clock, watchdog and test sequence
    // ------------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // The sequence needs about 120 cycles; this allows over thirty times that
    initial begin
        #200000;
        error_cnt++;
        complete_run();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {periph_ctrl, periph_oe, periph_out, analog_sel} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) rd("pad reg", 8'(8'h40 + 4 * i), 32'h0000_0000);
        pads(16'hFFFF, 16'h0000, 16'h0000, 16'h0000);
        $display("test reset done");
        apb(1'b1, 8'h40, 32'h0000_FFFF);
        pads(16'hFFFF, 16'hFFFF, 16'h0000, 16'h0000);
        rd("pull state", 8'h4C, 32'h0000_FFFF);
        apb(1'b1, 8'h00, 32'h0000_00A5);
        apb(1'b1, 8'h04, 32'h0000_00FF);
        apb(1'b1, 8'h44, 32'h0000_0F0F);
        apb(1'b1, 8'h48, 32'h0000_3333);
        pads(16'hFF00, 16'hFF00, 16'h000F, 16'h0033);
        chk("pad_out", {16'h0000, pad_out}, 32'h0000_00A5);
        rd("dir", 8'h04, 32'h0000_00FF);
        rd("data", 8'h00, 32'h0000_FFA5);
        rd("drive state", 8'h50, 32'h0000_00FF);
        $display("test gpio done");
        @(posedge pclk);
        periph_ctrl <= 16'hF000;
        periph_oe <= 16'h3000;
        periph_out <= 16'h1000;
        pads(16'hCF00, 16'hCF00, 16'h000F, 16'h3033);
        chk("pad_out", {16'h0000, pad_out}, 32'h0000_10A5);
        rd("data", 8'h00, 32'h0000_DFA5);
        $display("test peripheral done");
        @(posedge pclk);
        analog_sel <= 16'h0101;
        pads(16'hCF01, 16'hCE00, 16'h000E, 16'h3032);
        $display("test analog done");
        apb(1'b1, 8'h08, 32'h0000_FFFF);
        chk("slverr", {31'h0, err}, 32'h0000_0001);
        rd("unmapped", 8'h08, 32'h0000_0000);
        apb(1'b1, 8'h4C, 32'h0000_0000);
        chk("slverr", {31'h0, err}, 32'h0000_0000);
        rd("pull state", 8'h4C, 32'h0000_CE00);
        $display("test errors done");
        @(posedge pclk);
        presetn <= 1'b0;
        periph_ctrl <= 16'h0000;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        pads(16'hFFFF, 16'h0000, 16'h0000, 16'h0000);
        for (int i = 0; i < 5; i++) rd("pad reg", 8'(8'h40 + 4 * i), 32'h0000_0000);
        rd("dir", 8'h04, 32'h0000_0000);
        $display("test second reset done");
        complete_run();
    end
endmodule // tb
